// [rtl/icev_consts.vh]
// Offsets, field positions, reset values and timing counts for the completion event block.
`ifndef ICEV_CONSTS_VH
`define ICEV_CONSTS_VH
`define ICEV_OFF_STATUS 12'h09c
`define ICEV_OFF_CTRL 12'h0a0
`define ICEV_OFF_DATA 12'h0a4
`define ICEV_OFF_ADDR 12'h0a8
`define ICEV_OFF_IMASK 12'h0b8
`define ICEV_BIT_DONE 0
`define ICEV_BIT_MASK 31
`define ICEV_BIT_PEND 30
`define ICEV_RST_MASK 1'b1
`define ICEV_RST_DATA 16'h0000
`define ICEV_RST_ADDR 30'h00000000
`define ICEV_RST_IMASK 1'b0
`define ICEV_HOLD_CYCLES 4'h2
`endif

// [rtl/icev_msg_port.v]
// Message write port: holds one posted write until the host takes it.
`timescale 1ns/1ps
module icev_msg_port (
    clk,
    rst_n,
    send,
    data_in,
    addr_in,
    msg_valid,
    msg_data,
    msg_addr,
    msg_ready,
    busy
);
    input clk;
    input rst_n;
    input send;
    input [15:0] data_in;
    input [31:0] addr_in;
    output msg_valid;
    output [15:0] msg_data;
    output [31:0] msg_addr;
    input msg_ready;
    output busy;
    reg msg_valid_q;
    reg [15:0] msg_data_q;
    reg [31:0] msg_addr_q;

    // A send loads one write; it stays valid until the host accepts it.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_valid_q <= 1'b0;
            msg_data_q <= 16'h0000;
            msg_addr_q <= 32'h00000000;
        end else if (send && !msg_valid_q) begin
            msg_valid_q <= 1'b1;
            msg_data_q <= data_in;
            msg_addr_q <= addr_in;
        end else if (msg_valid_q && msg_ready) begin
            msg_valid_q <= 1'b0;
        end
    end

    assign msg_valid = msg_valid_q;
    assign msg_data = msg_data_q;
    assign msg_addr = msg_addr_q;
    assign busy = msg_valid_q;
endmodule // icev_msg_port

// [rtl/icev_top.v]
// Completion event logic for a queued invalidation engine with APB registers.
// Register map, one 32-bit word each:
//   0x09c completion status: bit 0 is the sticky done flag, write one to clear.
//   0x0a0 event control: bit 31 message mask, bit 30 pending, read only.
//   0x0a4 message data: bits 15:0 go out as the data of the posted write.
//   0x0a8 message address: bits 31:2, the two low bits always read zero.
//   0x0b8 interrupt enable: bit 0 lets the done flag drive the level interrupt.
// Every other word reads zero and answers with an error; reserved bits read zero.
//
// Flow of one event: a completion sets the flag and, if the flag was clear,
// the pending bit as well. Once the mask is clear and nothing holds the message
// back, the pending bit turns into a one-cycle send request, and the message
// port keeps the posted write up until the host takes it.
//
// Limitations: no upper message address word is kept, so every message lands
// below the 4 GB line; software that needs more must remap on the host side.
//
`timescale 1ns/1ps
`include "icev_consts.vh"
module icev_top (
    clk,
    rst_b,
    qi_supported,
    wait_done_event,
    host_busy,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    msg_valid,
    msg_data,
    msg_addr,
    msg_ready,
    irq
);
    input clk;
    input rst_b;
    input qi_supported;
    input wait_done_event;
    input host_busy;
    input psel;
    input penable;
    input pwrite;
    input [11:0] paddr;
    input [31:0] pwdata;
    output [31:0] prdata;
    output pready;
    output pslverr;
    output msg_valid;
    output [15:0] msg_data;
    output [31:0] msg_addr;
    input msg_ready;
    output irq;

    reg [1:0] rst_sync_q;
    wire rst_n;
    reg done_q;
    reg mask_q;
    reg pend_q;
    reg [15:0] data_q;
    reg [29:0] addr_q;
    reg imask_q;
    reg [31:0] prdata_q;
    reg pready_q;
    reg pslverr_q;
    reg irq_q;
    reg send_q;
    reg [3:0] hold_q;
    wire port_busy;
    wire [31:0] port_addr;
    wire apb_acc;
    wire apb_wr;
    wire hit_status;
    wire hit_ctrl;
    wire hit_data;
    wire hit_addr;
    wire hit_imask;
    wire done_clr;
    wire done_set;
    wire new_cond;
    wire held;
    wire fire;
    wire rd_en;
    wire hit_any;
    wire [4:0] hit;
    wire [59:0] reg_offs;
    reg done_d;
    reg pend_d;
    reg [31:0] rdata_d;
    genvar gi;

    // Reset is released through two flops so that its removal is clean.
    // Assertion stays asynchronous, so the block is quiet even without a clock;
    // only the release waits for the clock and cannot land in mid-edge.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Access phase decode; the slave answers in the cycle after penable rises.
    // Taking the access only while pready is low keeps the answer cycle from
    // counting as a second access of the same transfer.
    assign apb_acc = psel && penable && !pready_q;
    assign apb_wr = apb_acc && pwrite;
    assign rd_en = apb_acc && !pwrite;

    // One comparator per mapped word, status first.
    assign reg_offs = {`ICEV_OFF_IMASK, `ICEV_OFF_ADDR, `ICEV_OFF_DATA, `ICEV_OFF_CTRL, `ICEV_OFF_STATUS};
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_hit
            assign hit[gi] = (paddr == reg_offs[gi*12 +: 12]);
        end
    endgenerate
    assign hit_status = hit[0];
    assign hit_ctrl = hit[1];
    assign hit_data = hit[2];
    assign hit_addr = hit[3];
    assign hit_imask = hit[4];
    assign hit_any = |hit;

    // Clear wins only if no new completion arrives in the same cycle.
    assign done_clr = apb_wr && hit_status && qi_supported && pwdata[`ICEV_BIT_DONE];
    assign done_set = wait_done_event && qi_supported;
    assign new_cond = done_set && !done_q;
    // A message is held by the mask, by host back-pressure or a busy port.
    // The hold count covers the cycles between a send and the port turning busy,
    // which would otherwise let one pending event go out twice.
    assign held = mask_q || host_busy || port_busy || (hold_q != 4'h0);
    assign fire = pend_q && !held && !done_clr;

    // Next value of the completion flag; a completion in the same cycle as a
    // clear keeps the flag set, so no finished wait is ever lost.
    always @* begin
        done_d = done_q;
        if (done_set) begin
            done_d = 1'b1;
        end else if (done_clr) begin
            done_d = 1'b0;
        end
    end

    // Completion flag, sticky until software writes a one.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    // Next value of the pending bit; a fresh condition beats a service clear,
    // but an event that lands on the clear of a set flag gets no message, since the flag stays set.
    always @* begin
        pend_d = pend_q;
        if (new_cond) begin
            pend_d = 1'b1;
        end else if (done_clr) begin
            pend_d = 1'b0;
        end else if (fire) begin
            pend_d = 1'b0;
        end
    end

    // Pending tracks one outstanding message.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // One send pulse per pending event; a short hold keeps a second one out.
    // The extra register stage costs a cycle of latency but keeps the port
    // load away from the long mask and busy path.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            send_q <= 1'b0;
            hold_q <= 4'h0;
        end else begin
            send_q <= fire;
            if (fire) begin
                hold_q <= `ICEV_HOLD_CYCLES;
            end else if (hold_q != 4'h0) begin
                hold_q <= hold_q - 4'h1;
            end
        end
    end

    // Writable control and message registers.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= `ICEV_RST_MASK;
            data_q <= `ICEV_RST_DATA;
            addr_q <= `ICEV_RST_ADDR;
            imask_q <= `ICEV_RST_IMASK;
        end else if (apb_wr) begin
            if (hit_ctrl && qi_supported) begin
                mask_q <= pwdata[`ICEV_BIT_MASK];
            end
            if (hit_data) begin
                data_q <= pwdata[15:0];
            end
            if (hit_addr) begin
                addr_q <= pwdata[31:2];
            end
            if (hit_imask) begin
                imask_q <= pwdata[`ICEV_BIT_DONE];
            end
        end
    end

    // Read data of the addressed word. Status and control read zero without
    // queue support; the message words stay readable either way.
    always @* begin
        rdata_d = 32'h00000000;
        if (hit_status && qi_supported) begin
            rdata_d = {31'h00000000, done_q};
        end else if (hit_ctrl && qi_supported) begin
            rdata_d = {mask_q, pend_q, 30'h00000000};
        end else if (hit_data) begin
            rdata_d = {16'h0000, data_q};
        end else if (hit_addr) begin
            rdata_d = {addr_q, 2'b00};
        end else if (hit_imask) begin
            rdata_d = {31'h00000000, imask_q};
        end
    end

    // Answer one cycle after the access starts; an unmapped word answers with an error and zero.
    // Read data is zero outside a read so the bus never shows stale register contents.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= apb_acc;
            pslverr_q <= apb_acc && !hit_any;
            if (rd_en) begin
                prdata_q <= rdata_d;
            end else begin
                prdata_q <= 32'h00000000;
            end
        end
    end

    // Level interrupt from the sticky flag; it shares the flag's clear.
    // It is independent of the message mask, so a polling driver can use the
    // line alone and leave messages masked.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= done_q && imask_q;
        end
    end

    assign port_addr = {addr_q, 2'b00};

    // The port registers the message so every output leaves a flop.
    // Data and address are captured at the send, so a later register write
    // never changes a message that the host has not yet taken.
    icev_msg_port u_port (
        .clk(clk),
        .rst_n(rst_n),
        .send(send_q),
        .data_in(data_q),
        .addr_in(port_addr),
        .msg_valid(msg_valid),
        .msg_data(msg_data),
        .msg_addr(msg_addr),
        .msg_ready(msg_ready),
        .busy(port_busy)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
endmodule // icev_top

// [tb/icev_assertions.sv]
// Port checker for the completion event block.
`timescale 1ns/1ps
module icev_chk (
    input logic clk, rst_b, qi_supported, wait_done_event, host_busy, psel, penable, pwrite,
    input logic pready, pslverr, msg_valid, msg_ready, irq,
    input logic [11:0] paddr,
    input logic [31:0] pwdata, prdata, msg_addr,
    input logic [15:0] msg_data
);
    logic m_q;
    logic [15:0] d_q;
    wire wr = psel && penable && !pready && pwrite;
    wire rdq = pready && !pwrite && qi_supported;
    // Mask and data as last written; a dropped write leaves the shadow alone.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) {m_q, d_q} <= {1'b1, 16'h0000};
        else if (wr && paddr == 12'h0a0 && qi_supported) m_q <= pwdata[31];
        else if (wr && paddr == 12'h0a4) d_q <= pwdata[15:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    mask_blocks_msg_a: assert property ($rose(msg_valid) |-> !$past(m_q, 2)) else $error("msg while masked");
    busy_holds_msg_a: assert property ($rose(msg_valid) |-> !$past(host_busy, 2)) else $error("msg while busy");
    msg_held_a: assert property (msg_valid && !msg_ready |=> msg_valid && $stable({msg_data, msg_addr}))
        else $error("msg not held");
    msg_data_a: assert property ($rose(msg_valid) |-> msg_data == $past(d_q)) else $error("msg data wrong");
    addr_align_a: assert property (msg_valid |-> msg_addr[1:0] == 2'b00) else $error("msg addr unaligned");
    one_write_a: assert property ($fell(msg_valid) |=> !msg_valid) else $error("msg repeated");
    qi_off_zero_a: assert property (pready && !pwrite && !qi_supported && paddr inside {12'h09c, 12'h0a0}
        |-> prdata == 32'h0) else $error("read not zero");
    mask_read_a: assert property (rdq && paddr == 12'h0a0 |-> prdata[31] == m_q) else $error("mask readback");
    cover property ($rose(msg_valid));
    cover property (msg_valid && !msg_ready);
    cover property (pslverr);
endmodule // icev_chk

// [tb/icev_host_model.sv]
// Host side model that takes posted message writes after a varying wait.
`timescale 1ns/1ps
module icev_host (
    input logic clk, msg_valid,
    input logic [15:0] msg_data,
    input logic [31:0] msg_addr,
    output logic msg_ready = 0,
    output logic [7:0] cnt = 0,
    output logic [47:0] last = 0
);
    // Each write is taken once; a random stall exercises the holding of the message.
    always @(posedge clk) begin
        if (msg_valid && msg_ready) {cnt, last} <= {cnt + 8'h01, msg_data, msg_addr};
        msg_ready <= msg_valid && !msg_ready && $urandom % 2;
    end
endmodule // icev_host

// [tb/test_invalidation_completion_event.sv]
// Self-checking bench for the completion event block.
`timescale 1ns/1ps
module test_invalidation_completion_event;
    logic clk = 0, rst_b = 0, qi = 1, ev = 0, busy = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, msg_valid, msg_ready, irq, err;
    logic [11:0] paddr = 0;
    logic [15:0] msg_data;
    logic [31:0] pwdata = 0, prdata, msg_addr, q, dv;
    logic [7:0] cnt;
    logic [47:0] last;
    int error_cnt = 0, n_tests = 0, i;
    // Free-running clock at 50 MHz.
    always #10 clk = ~clk;
    icev_top icev_top_inst (.clk(clk), .rst_b(rst_b), .qi_supported(qi), .wait_done_event(ev), .host_busy(busy),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid), .msg_data(msg_data), .msg_addr(msg_addr),
        .msg_ready(msg_ready), .irq(irq));
    icev_host icev_host_inst (.clk(clk), .msg_valid(msg_valid), .msg_data(msg_data), .msg_addr(msg_addr),
        .msg_ready(msg_ready), .cnt(cnt), .last(last));
    // Prints the counts and the verdict, then ends the run.
    task test_done;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; the request stands until pready is sampled high.
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk("read", e, q);
    endtask
    task wt;
        repeat (40) @(posedge clk);
    endtask
    // One completion of a wait descriptor that asks for an interrupt.
    task pulse;
        @(posedge clk) ev <= 1'b1;
        @(posedge clk) ev <= 1'b0;
        wt;
    endtask
    function logic [31:0] ctl(input logic m, input logic p);
        return {m, p, 30'h0};
    endfunction
    // Main sequence: reset, then each scenario in turn.
    initial begin
        void'($urandom(32'h477ebbee));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd(12'h0a0, ctl(1, 0));
        rd(12'h09c, 32'h0);
        dv = $urandom;
        apb(12'h0a4, 1, dv);
        apb(12'h0a8, 1, dv);
        rd(12'h0a8, {dv[31:2], 2'b00});
        pulse;
        rd(12'h0a0, ctl(1, 1));
        rd(12'h09c, 32'h1);
        chk("count", 0, cnt);
        apb(12'h0a0, 1, 32'h0);
        wt;
        chk("count", 1, cnt);
        chk("msg", {dv[15:0], dv[31:2], 2'b00}, last);
        rd(12'h0a0, 32'h0);
        pulse;
        rd(12'h0a0, 32'h0);
        chk("count", 1, cnt);
        // Interrupt line: raised, masked by its enable, then cleared with the flag.
        apb(12'h0b8, 1, 32'h1);
        wt;
        chk("irq", 1, irq);
        apb(12'h0b8, 1, 32'h0);
        wt;
        chk("irq", 0, irq);
        apb(12'h0b8, 1, 32'h1);
        apb(12'h09c, 1, 32'h1);
        wt;
        chk("irq", 0, irq);
        rd(12'h09c, 32'h0);
        apb(12'h0a0, 1, 32'h80000000);
        pulse;
        apb(12'h09c, 1, 32'h1);
        rd(12'h0a0, ctl(1, 0));
        apb(12'h0a0, 1, 32'h0);
        wt;
        chk("count", 1, cnt);
        busy <= 1'b1;
        pulse;
        rd(12'h0a0, ctl(0, 1));
        chk("count", 1, cnt);
        busy <= 1'b0;
        wt;
        chk("count", 2, cnt);
        apb(12'h09c, 1, 32'h1);
        for (i = 0; i < 4; i++) begin
            dv = $urandom;
            apb(12'h0a4, 1, dv);
            pulse;
            chk("data", dv[15:0], last[47:32]);
            apb(12'h09c, 1, 32'h1);
        end
        chk("count", 6, cnt);
        apb(12'hffc, 1, $urandom);
        chk("slverr", 1, err);
        qi <= 1'b0;
        apb(12'h0a0, 1, 32'h80000000);
        rd(12'h0a0, 32'h0);
        rd(12'h09c, 32'h0);
        qi <= 1'b1;
        rd(12'h0a0, ctl(0, 0));
        test_done;
    end
    // A hang counts as a mismatch and ends the run the usual way.
    initial begin
        #1000000;
        error_cnt++;
        test_done;
    end
endmodule // test_invalidation_completion_event
bind icev_top icev_chk icev_chk_inst (.clk(clk), .rst_b(rst_b), .qi_supported(qi_supported),
    .wait_done_event(wait_done_event), .host_busy(host_busy), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid), .msg_ready(msg_ready), .irq(irq),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .msg_addr(msg_addr), .msg_data(msg_data));
